// >>> shared/wdg_pkg.sv
// Constants for the free-running watchdog downcounter
`default_nettype none
package wdg_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] CTRL_ADDR = 8'h2A;
  localparam int ACT_BIT = 7;
  localparam int TOP_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h7F;
  localparam logic [6:0] TRIG_COUNT = 7'h40;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_PULSE_NS = 500;
  localparam int RST_PULSE_CYC = RST_PULSE_NS / CLK_PERIOD_NS;
  localparam int PRESCALE_CYC = 16384;
  localparam int UNITS_PER_STEP = 256;
  localparam logic [8:0] SHORT_BASE = 9'h0C0;
  localparam logic [7:0] ACC_STEP = 8'h04;

  // ************************************************************
  // Timebase correction figures
  // ************************************************************
  function automatic logic [7:0] tb_msb(input logic [1:0] sel);
    case (sel)
      2'b00: tb_msb = 8'h04;
      2'b01: tb_msb = 8'h08;
      2'b10: tb_msb = 8'h14;
      default: tb_msb = 8'h31;
    endcase
  endfunction

  function automatic logic [8:0] tb_lsb(input logic [1:0] sel);
    case (sel)
      2'b00: tb_lsb = 9'h03B;
      2'b01: tb_lsb = 9'h035;
      2'b10: tb_lsb = 9'h023;
      default: tb_lsb = 9'h036;
    endcase
  endfunction

  // Controller states, one-hot
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_PULSE = 2'b10
  } wdg_state_e;
endpackage
`default_nettype wire

// >>> hdl/wdg_downcounter.sv
// Windowless watchdog: prescaler, 7-bit downcounter and reset pulse
// Notes on behaviour
// - Count decrements every 16384 clocks or a shorter trimmed step, prescaler free
// - Low six count bits set timeout steps
// - Active and 40h to 3Fh starts reset
// - Reset pin held low about 500 ns
// - Counting continues while watchdog is inactive
// - Writes load count, prescaler keeps running
// - After reset the watchdog is inactive
// - Activation sticks; only reset clears it
// - Activate with top bit clear forces reset
// - Active plus halt gives reset when optioned
// - Option input picks halt reset behaviour
// - Option input selects hardware watchdog mode
// - Timebase select trims exact step lengths
// - Bit 7 activation, bits 6:0 count, 7Fh
// - Software sets activation, hardware clears on reset
// - Hardware mode: always active, bit ignored
`default_nettype none
module wdg_downcounter
  import wdg_pkg::*;
#(
  parameter int PRESCALE_CYCLES = PRESCALE_CYC,
  parameter int PULSE_CYCLES = RST_PULSE_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Options and clock controller
  input wire logic [1:0] timebase_select_in,
  input wire logic hw_watchdog_option_in,
  input wire logic halt_reset_option_in,
  // Processor power events
  input wire logic halt_exec_in,
  input wire logic wake_in,
  // Reset pin drive, low while reset is pulled
  output logic wdg_reset_n_out
);
  localparam int UNIT_CYC = PRESCALE_CYCLES / UNITS_PER_STEP;

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (UNIT_CYC < 1 || UNIT_CYC > 65536 ||
      UNIT_CYC * UNITS_PER_STEP != PRESCALE_CYCLES) begin : g_bad_pre
    $error("PRESCALE_CYCLES must be a multiple of 256 that the 16-bit sub counter serves");
  end
  if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255) begin : g_bad_pulse
    $error("PULSE_CYCLES must be 1 to 255");
  end

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [15:0] sub_r;
  logic [8:0] unit_r;
  logic [7:0] acc_r;
  logic [6:0] count_r;
  logic activate_r;
  logic halted_r;
  logic frozen_r;
  logic [7:0] pulse_r;
  wdg_state_e state_r;
  logic [7:0] msb_w;
  logic [8:0] lsb_w;
  logic short_w;
  logic [8:0] step_len_w;
  logic sub_end_w;
  logic tick_w;
  logic dec_w;
  logic ctrl_wr_w;
  logic ctrl_rd_w;
  logic armed_w;
  logic wr_armed_w;
  logic trig_count_w;
  logic trig_soft_w;
  logic trig_halt_w;
  logic trigger_w;
  logic pulse_end_w;

  // ************************************************************
  // Decode and trigger terms
  // ************************************************************
  // Register strobes
  assign ctrl_wr_w = reg_wr_in && (reg_addr_in == CTRL_ADDR) && (state_r == ST_RUN);
  assign ctrl_rd_w = reg_rd_in && (reg_addr_in == CTRL_ADDR);

  // Effective activation: hardware mode overrides the bit
  assign armed_w = activate_r || hw_watchdog_option_in;
  assign wr_armed_w = armed_w || reg_wdata_in[ACT_BIT];

  // Step length trimmed by timebase selection
  assign msb_w = tb_msb(timebase_select_in);
  assign lsb_w = tb_lsb(timebase_select_in);
  assign short_w = (acc_r + ACC_STEP) >= msb_w;
  assign step_len_w = short_w ? (SHORT_BASE + lsb_w) : 9'(UNITS_PER_STEP);

  // Prescaler end of step
  assign sub_end_w = (sub_r == 16'(UNIT_CYC - 1));
  assign tick_w = sub_end_w && ((unit_r + 9'h001) >= step_len_w);
  assign dec_w = tick_w && !frozen_r && (state_r == ST_RUN);

  // Reset causes
  assign trig_count_w = dec_w && !ctrl_wr_w && armed_w && (count_r == TRIG_COUNT);
  assign trig_soft_w = ctrl_wr_w && wr_armed_w && !reg_wdata_in[TOP_BIT];
  assign trig_halt_w = halt_exec_in && armed_w && halt_reset_option_in && (state_r == ST_RUN);
  assign trigger_w = trig_count_w || trig_soft_w || trig_halt_w;
  assign pulse_end_w = (state_r == ST_PULSE) && (pulse_r == 8'(PULSE_CYCLES - 1));

  // ************************************************************
  // Free-running prescaler
  // ************************************************************
  // Never cleared by register writes
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sub_r <= 16'h0000;
      unit_r <= 9'h000;
    end else if (sub_end_w) begin
      sub_r <= 16'h0000;
      unit_r <= tick_w ? 9'h000 : unit_r + 9'h001;
    end else begin
      sub_r <= sub_r + 16'h0001;
    end
  end

  // Spreads the short steps over the count
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_r <= 8'h00;
    end else if (tick_w) begin
      acc_r <= short_w ? (acc_r + ACC_STEP - msb_w) : (acc_r + ACC_STEP);
    end
  end

  // ************************************************************
  // Counter and activation
  // ************************************************************
  // Write wins over a decrement in the same cycle
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      count_r <= CTRL_RESET[6:0];
    end else if (pulse_end_w) begin
      count_r <= CTRL_RESET[6:0];
    end else if (ctrl_wr_w) begin
      count_r <= reg_wdata_in[6:0];
    end else if (dec_w) begin
      count_r <= count_r - 7'h01;
    end
  end

  // Set by software only, cleared only by reset
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      activate_r <= 1'b0;
    end else if (pulse_end_w) begin
      activate_r <= 1'b0;
    end else if (ctrl_wr_w && reg_wdata_in[ACT_BIT]) begin
      activate_r <= 1'b1;
    end
  end

  // ************************************************************
  // Halt handling
  // ************************************************************
  // Without halt reset: one more decrement, then frozen; halt beats a same-cycle wake
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      halted_r <= 1'b0;
      frozen_r <= 1'b0;
    end else if (halt_exec_in && !trig_halt_w && !pulse_end_w) begin
      halted_r <= 1'b1;
    end else if (wake_in || pulse_end_w) begin
      halted_r <= 1'b0;
      frozen_r <= 1'b0;
    end else if (halted_r && dec_w) begin
      frozen_r <= 1'b1;
    end
  end

  // ************************************************************
  // Reset pulse sequencer
  // ************************************************************
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_RUN;
      pulse_r <= 8'h00;
    end else begin
      case (state_r)
        ST_RUN: begin
          pulse_r <= 8'h00;
          if (trigger_w) begin
            state_r <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          pulse_r <= pulse_r + 8'h01;
          if (pulse_end_w) begin
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_RUN;
          pulse_r <= 8'h00;
        end
      endcase
    end
  end

  // Pin drive from a flip-flop
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wdg_reset_n_out <= 1'b1;
    end else begin
      wdg_reset_n_out <= !((state_r == ST_RUN && trigger_w) ||
                           (state_r == ST_PULSE && !pulse_end_w));
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  // Valid only in the cycle after the strobe
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= RDATA_IDLE;
    end else if (ctrl_rd_w) begin
      reg_rdata_out <= {activate_r, count_r};
    end else begin
      reg_rdata_out <= RDATA_IDLE;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  // Length of each low pulse on the pin
  logic [7:0] low_len_r;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      low_len_r <= 8'h00;
    end else if (!wdg_reset_n_out) begin
      low_len_r <= low_len_r + 8'h01;
    end else begin
      low_len_r <= 8'h00;
    end
  end

  // Cycles since last prescaler tick
  logic [23:0] gap_r;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      gap_r <= 24'h000000;
    end else if (tick_w) begin
      gap_r <= 24'h000000;
    end else begin
      gap_r <= gap_r + 24'h000001;
    end
  end

  tick_gap_a: assert property (
    tick_w && $past(tick_w, 2) == 1'b0 && gap_r != 24'h000000 |->
      gap_r + 24'h1 <= 24'(PRESCALE_CYCLES))
    else $error("prescaler step longer than nominal");

  count_trig_a: assert property (
    trig_count_w |=> state_r == ST_PULSE ##1 !wdg_reset_n_out)
    else $error("count reaching 3Fh did not start reset");

  pulse_width_a: assert property (
    $rose(wdg_reset_n_out) |-> low_len_r == 8'(PULSE_CYCLES))
    else $error("reset pulse length wrong");

  free_count_a: assert property (
    !armed_w && dec_w && !ctrl_wr_w |=> count_r == $past(count_r) - 7'h01)
    else $error("counter stalled while inactive");

  write_load_a: assert property (
    ctrl_wr_w && reg_wdata_in[TOP_BIT] |=>
      count_r == $past(reg_wdata_in[6:0]) &&
      activate_r == ($past(activate_r) || $past(reg_wdata_in[ACT_BIT])))
    else $error("write did not load register");

  sticky_act_a: assert property (
    activate_r && state_r == ST_RUN |=> activate_r)
    else $error("activation dropped without reset");

  soft_reset_a: assert property (
    trig_soft_w |=> !wdg_reset_n_out [*2])
    else $error("software reset not generated");

  halt_reset_a: assert property (
    halt_exec_in && armed_w && halt_reset_option_in && state_r == ST_RUN |=> !wdg_reset_n_out)
    else $error("halt did not reset");

  hw_mode_a: assert property (
    hw_watchdog_option_in && dec_w && !ctrl_wr_w && count_r == TRIG_COUNT |=>
      state_r == ST_PULSE)
    else $error("hardware mode ignored");

  post_reset_a: assert property (
    pulse_end_w |=> !activate_r && count_r == CTRL_RESET[6:0])
    else $error("state not reset after pulse");

  read_back_a: assert property (
    ctrl_rd_w |=> reg_rdata_out == {$past(activate_r), $past(count_r)})
    else $error("read data mismatch");

  cov_count_c: cover property (trig_count_w);
  cov_soft_c: cover property (trig_soft_w);
  cov_halt_c: cover property (trig_halt_w);
  free_prescale_a: assert property (
    ctrl_wr_w && !sub_end_w |=> sub_r == $past(sub_r) + 16'h0001)
    else $error("write disturbed the prescaler");

  inactive_quiet_a: assert property (
    !armed_w && !ctrl_wr_w && state_r == ST_RUN |=> wdg_reset_n_out)
    else $error("reset pulled while inactive");

  halt_freeze_a: assert property (
    frozen_r && !ctrl_wr_w && !pulse_end_w |=> $stable(count_r))
    else $error("count moved while frozen");

  pulse_wr_block_a: assert property (
    reg_wr_in && reg_addr_in == CTRL_ADDR && state_r == ST_PULSE && !pulse_end_w |=>
      $stable(count_r) && $stable(activate_r))
    else $error("write taken during reset pulse");

  cov_freeze_c: cover property (halted_r && dec_w ##1 frozen_r);
  cov_hw_c: cover property (hw_watchdog_option_in && !activate_r && trig_count_w);
endmodule
`default_nettype wire

// >>> verification/windowless_watchdog_downcounter_tb.sv
// Self-checking bench for the watchdog downcounter
`default_nettype none
module windowless_watchdog_downcounter_tb
  import wdg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ************************************************************
  // Settings and signals
  // ************************************************************
  localparam int PRE = 512;
  localparam int PULSE = 50;
  localparam int LIMIT = 30000;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rdata;
  logic [1:0] tb_sel = 2'h0;
  logic hw_opt = 1'b0;
  logic halt_opt = 1'b0;
  logic halt_exec = 1'b0;
  logic wake = 1'b0;
  logic pin_n;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  logic [7:0] d;
  logic [7:0] r1;

  // Clock, 10 ns period
  always #5 mclk_in = ~mclk_in;

  wdg_downcounter #(.PRESCALE_CYCLES(PRE), .PULSE_CYCLES(PULSE)) dut (
    .mclk_in(mclk_in), .rst_in(rst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_en), .reg_rd_in(rd_en),
    .reg_rdata_out(rdata), .timebase_select_in(tb_sel),
    .hw_watchdog_option_in(hw_opt), .halt_reset_option_in(halt_opt),
    .halt_exec_in(halt_exec), .wake_in(wake), .wdg_reset_n_out(pin_n)
  );

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic test_done();
    $display("Comparisons %0d, errors %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      test_done();
    end
  end

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chkn(input string what, input int lo, input int hi, input int got);
    comparisons++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge mclk_in);
    wr_en <= 1'b0;
    #1;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk_in);
    rd_en <= 1'b0;
    #1;
    v = rdata;
  endtask

  // One-cycle halt or wake event
  task automatic pulse(input bit is_halt);
    @(posedge mclk_in);
    if (is_halt) halt_exec <= 1'b1;
    else wake <= 1'b1;
    @(posedge mclk_in);
    halt_exec <= 1'b0;
    wake <= 1'b0;
    #1;
  endtask

  task automatic wait_low(input int max, output int cnt);
    cnt = 0;
    while (pin_n !== 1'b0 && cnt < max) begin
      @(posedge mclk_in);
      #1;
      cnt++;
    end
  endtask

  task automatic low_len(output int cnt);
    cnt = 0;
    while (pin_n === 1'b0 && cnt < 300) begin
      @(posedge mclk_in);
      #1;
      cnt++;
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    #1;
    reg_read(CTRL_ADDR, d);
    chk8("ctrl after reset", CTRL_RESET, d);
    chk1("pin after reset", 1'b1, pin_n);
    // Unmapped place: no effect, reads idle
    reg_write(8'h2B, 8'h80);
    reg_read(8'h2B, d);
    chk8("unmapped read", RDATA_IDLE, d);
    chk1("unmapped write", 1'b1, pin_n);
    // Inactive: count runs past 40h with no reset
    reg_write(CTRL_ADDR, 8'h41);
    wait_low(1200, n);
    chkn("no reset inactive", 1200, 1200, n);
    reg_read(CTRL_ADDR, d);
    chk8("count below 40h", 8'h00, d & 8'hC0);
    // Activate, then try to clear the bit
    reg_write(CTRL_ADDR, 8'hFF);
    reg_read(CTRL_ADDR, d);
    chk8("activate", 8'hFF, d);
    reg_write(CTRL_ADDR, 8'h7F);
    reg_read(CTRL_ADDR, d);
    chk8("activation sticks", 8'hFF, d);
    // Halt without reset option: count freezes until wake
    pulse(1'b1);
    idle(600);
    reg_read(CTRL_ADDR, r1);
    idle(1200);
    reg_read(CTRL_ADDR, d);
    chk8("frozen count", r1, d);
    chk1("no halt reset", 1'b1, pin_n);
    pulse(1'b0);
    idle(1200);
    reg_read(CTRL_ADDR, d);
    chk1("count resumes", 1'b1, d < r1);
    // Software reset; a write inside the pulse is refused
    reg_write(CTRL_ADDR, 8'h80);
    chk1("sw reset pin", 1'b0, pin_n);
    reg_write(CTRL_ADDR, 8'hFF);
    reg_read(CTRL_ADDR, d);
    chk8("write in pulse", 8'h80, d);
    low_len(n);
    chkn("sw pulse rest", PULSE - 4, PULSE - 4, n);
    reg_read(CTRL_ADDR, d);
    chk8("after sw reset", CTRL_RESET, d);
    // Halt with reset option
    @(posedge mclk_in) halt_opt <= 1'b1;
    reg_write(CTRL_ADDR, 8'hFF);
    pulse(1'b1);
    chk1("halt reset", 1'b0, pin_n);
    low_len(n);
    chkn("halt pulse", PULSE, PULSE, n);
    @(posedge mclk_in) halt_opt <= 1'b0;
    // Timeout from 41h under every timebase
    for (int t = 0; t < 4; t++) begin
      @(posedge mclk_in) tb_sel <= 2'(t);
      reg_write(CTRL_ADDR, 8'hC1);
      wait_low(1100, n);
      chkn("timeout", 400, 1099, n);
      low_len(n);
      chkn("wdg pulse", PULSE, PULSE, n);
    end
    // Hardware mode arms without the activation bit
    @(posedge mclk_in) hw_opt <= 1'b1;
    reg_write(CTRL_ADDR, 8'h41);
    reg_read(CTRL_ADDR, d);
    chk8("hw mode bit", 8'h41, d);
    wait_low(1100, n);
    chkn("hw timeout", 400, 1099, n);
    low_len(n);
    chkn("hw pulse", PULSE, PULSE, n);
    @(posedge mclk_in) hw_opt <= 1'b0;
    test_done();
  end
endmodule
`default_nettype wire
